/* File: pkg/opmode_pkg.sv */
// constants and types shared by the operation mode control block
package opmode_pkg;
    localparam int AW = 4;
    localparam logic [AW-1:0] OFS_MODE   = 4'h0;
    localparam logic [AW-1:0] OFS_STATUS = 4'h4;
    localparam logic [AW-1:0] OFS_STATE  = 4'h8;
    localparam logic [AW-1:0] OFS_POLL   = 4'hC;

    // mode register fields
    localparam int B_THR_SPEED   = 22;
    localparam int B_THR_HI      = 15;
    localparam int B_THR_LO      = 14;
    localparam int B_TX_RUN      = 13;
    localparam int B_FORCE_COLL  = 12;
    localparam int B_LOOP_HI     = 11;
    localparam int B_LOOP_LO     = 10;
    localparam int B_FULL_DUPLEX = 9;
    localparam int B_ALL_MCAST   = 7;
    localparam int B_PROMISC     = 6;
    localparam int B_BAD_FRAMES  = 3;
    localparam int B_HASH_ONLY   = 2;
    localparam int B_RX_RUN      = 1;
    localparam int B_HASH_PERF   = 0;
    localparam logic [31:0] MODE_RESET = 32'h0040_0040;

    // status register flags, write one to clear
    localparam int B_TX_STOPPED = 1;
    localparam int B_TX_UNAVAIL = 2;
    localparam int B_RX_UNAVAIL = 7;
    localparam int B_RX_STOPPED = 8;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

    // poll register bits
    localparam int B_TX_POLL = 0;
    localparam int B_RX_POLL = 1;

    localparam logic [1:0] LOOP_NORMAL   = 2'h0;
    localparam logic [1:0] LOOP_INTERNAL = 2'h1;
    localparam logic [1:0] LOOP_EXTERNAL = 2'h2;
    localparam logic [1:0] LOOP_PHY      = 2'h3;

    localparam int THR_W = 11;
    localparam logic [THR_W-1:0] THR_FAST_0 = 11'h080;
    localparam logic [THR_W-1:0] THR_FAST_1 = 11'h100;
    localparam logic [THR_W-1:0] THR_FAST_2 = 11'h200;
    localparam logic [THR_W-1:0] THR_FAST_3 = 11'h400;
    localparam logic [THR_W-1:0] THR_SLOW_0 = 11'h040;
    localparam logic [THR_W-1:0] THR_SLOW_1 = 11'h080;
    localparam logic [THR_W-1:0] THR_SLOW_2 = 11'h0C0;
    localparam logic [THR_W-1:0] THR_SLOW_3 = 11'h100;

    typedef enum logic [2:0] {
        PROC_STOPPED,
        PROC_FETCH,
        PROC_WAIT_DESC,
        PROC_RUNNING,
        PROC_SUSPENDED
    } proc_state_t;
endpackage : opmode_pkg

/* File: pkg/filter_if.sv */
// filter modes, frame attributes and verdict between control and filter
`timescale 1ns/1ps
interface filter_if;
    logic promisc;
    logic all_mcast;
    logic bad_ok;
    logic hash_only;
    logic hash_perf;
    logic frame_valid;
    logic is_mcast;
    logic is_bad;
    logic perfect_hit;
    logic hash_hit;
    logic accept;

    modport ctrl (
        output promisc, all_mcast, bad_ok, hash_only, hash_perf,
        output frame_valid, is_mcast, is_bad, perfect_hit, hash_hit,
        input  accept
    );
    modport filt (
        input  promisc, all_mcast, bad_ok, hash_only, hash_perf,
        input  frame_valid, is_mcast, is_bad, perfect_hit, hash_hit,
        output accept
    );
endinterface : filter_if

/* File: rtl/rx_addr_filter.sv */
// receive address filter verdict
`timescale 1ns/1ps
module rx_addr_filter (
    filter_if.filt f
);
    wire mcast_hit;
    wire phys_hit;
    wire addr_ok;
    wire quality_ok;

    // hash-only wins for every address class
    assign mcast_hit = (f.hash_perf | f.hash_only) ? f.hash_hit
                                                   : f.perfect_hit;
    assign phys_hit  = f.hash_only ? f.hash_hit : f.perfect_hit;
    assign addr_ok   = f.promisc
                     | (f.is_mcast & f.all_mcast)
                     | (f.is_mcast ? mcast_hit : phys_hit);
    // bad frames still face the address check unless promiscuous
    assign quality_ok = ~f.is_bad | f.bad_ok;
    assign f.accept   = f.frame_valid & addr_ok & quality_ok;
endmodule : rx_addr_filter

/* File: rtl/mac_operation_mode_control.sv */
// operation mode register, transmit and receive process control over APB
// Notes on behaviour
// - transmit run bit starts descriptor fetch
// - host-owned tx descriptor suspends, flags unavailable
// - owned descriptor: fill FIFO, send at threshold
// - tx run cleared: finish frame, then stop
// - force collision only in internal loopback
// - loopback field: normal, internal, external, PHY
// - external loopback disables collision detection
// - duplex bit: PHY status or software choice
// - pass all multicast frames when set
// - promiscuous accepts every valid frame, except bad frames when the bad-frames bit is clear
// - promiscuous enabled after reset
// - bad frames delivered, still address filtered
// - hash-only indicator read-only, from setup frame
// - receive run bit starts descriptor fetch
// - owned rx descriptor: keep running, wait
// - rx run cleared: finish frame, then stop
// - hash/perfect zero means perfect filtering
// - hash/perfect one hashes multicast addresses
// - threshold from speed bit and level bits
`timescale 1ns/1ps
module mac_operation_mode_control (
    input  wire logic                         pclk,
    input  wire logic                         presetn,
    input  wire logic                         psel,
    input  wire logic                         penable,
    input  wire logic                         pwrite,
    input  wire logic [31:0]                  paddr,
    input  wire logic [31:0]                  pwdata,
    output logic      [31:0]                  prdata,
    output logic                              pready,
    output logic                              pslverr,
    // setup frame results and PHY status
    input  wire logic                         setup_load,
    input  wire logic                         setup_hash_only,
    input  wire logic                         setup_hash_perfect,
    input  wire logic                         ext_phy_select,
    input  wire logic                         phy_full_duplex,
    // transmit descriptor and FIFO side
    output logic                              tx_desc_fetch,
    input  wire logic                         tx_desc_valid,
    input  wire logic                         tx_desc_device_owned,
    output logic                              tx_move_data,
    input  wire logic [opmode_pkg::THR_W-1:0] tx_fifo_level,
    output logic                              tx_send_start,
    input  wire logic                         tx_frame_busy,
    input  wire logic                         tx_frame_done,
    // receive descriptor and frame side
    output logic                              rx_desc_fetch,
    input  wire logic                         rx_desc_valid,
    input  wire logic                         rx_desc_device_owned,
    input  wire logic                         rx_frame_busy,
    input  wire logic                         rx_frame_done,
    input  wire logic                         rx_frame_valid,
    input  wire logic                         rx_is_multicast,
    input  wire logic                         rx_is_bad,
    input  wire logic                         rx_perfect_hit,
    input  wire logic                         rx_hash_hit,
    output logic                              rx_accept,
    output logic                              rx_running,
    // line side mode outputs
    output logic [1:0]                        loopback_mode,
    output logic                              force_collision_active,
    output logic                              collision_detect_enable,
    output logic                              full_duplex_active,
    output logic [opmode_pkg::THR_W-1:0]      tx_threshold
);
    logic [31:0]             mode_reg;
    logic [31:0]             status_reg;
    logic                    hash_only_reg;
    logic                    hash_perf_reg;
    opmode_pkg::proc_state_t tx_state_reg;
    opmode_pkg::proc_state_t tx_state_next;
    opmode_pkg::proc_state_t rx_state_reg;
    opmode_pkg::proc_state_t rx_state_next;
    logic                    tx_unavail_set;
    logic                    tx_stop_set;
    logic                    rx_unavail_set;
    logic                    rx_stop_set;

    filter_if fif ();

    // ---- APB decode ----
    wire [opmode_pkg::AW-1:0] reg_addr = paddr[opmode_pkg::AW-1:0];
    wire addr_hit  = (paddr[31:opmode_pkg::AW] == '0);
    wire sel_mode   = addr_hit && reg_addr == opmode_pkg::OFS_MODE;
    wire sel_status = addr_hit && reg_addr == opmode_pkg::OFS_STATUS;
    wire sel_state  = addr_hit && reg_addr == opmode_pkg::OFS_STATE;
    wire sel_poll   = addr_hit && reg_addr == opmode_pkg::OFS_POLL;
    wire mapped     = sel_mode | sel_status | sel_state | sel_poll;
    // one wait state; registers change only at the completing edge
    wire access     = psel & penable;
    wire done       = access & pready;
    wire wr_done    = done & pwrite & mapped;
    wire wr_mode    = wr_done & sel_mode;
    wire wr_status  = wr_done & sel_status;
    wire wr_poll    = wr_done & sel_poll;
    wire tx_poll    = wr_poll & pwdata[opmode_pkg::B_TX_POLL];
    wire rx_poll    = wr_poll & pwdata[opmode_pkg::B_RX_POLL];

    // ---- mode bits ----
    wire       tx_cmd     = mode_reg[opmode_pkg::B_TX_RUN];
    wire       rx_cmd     = mode_reg[opmode_pkg::B_RX_RUN];
    wire [1:0] loop_sel   = mode_reg[opmode_pkg::B_LOOP_HI:
                                     opmode_pkg::B_LOOP_LO];
    wire       thr_speed  = mode_reg[opmode_pkg::B_THR_SPEED];
    wire [1:0] thr_level  = mode_reg[opmode_pkg::B_THR_HI:
                                     opmode_pkg::B_THR_LO];
    wire       duplex_eff = ext_phy_select
                          ? mode_reg[opmode_pkg::B_FULL_DUPLEX]
                          : phy_full_duplex;

    // only implemented bits are writable; the rest never store
    wire [31:0] mode_wmask = (32'h1 << opmode_pkg::B_THR_SPEED)
                           | (32'h1 << opmode_pkg::B_THR_HI)
                           | (32'h1 << opmode_pkg::B_THR_LO)
                           | (32'h1 << opmode_pkg::B_TX_RUN)
                           | (32'h1 << opmode_pkg::B_FORCE_COLL)
                           | (32'h1 << opmode_pkg::B_LOOP_HI)
                           | (32'h1 << opmode_pkg::B_LOOP_LO)
                           | (32'h1 << opmode_pkg::B_FULL_DUPLEX)
                           | (32'h1 << opmode_pkg::B_ALL_MCAST)
                           | (32'h1 << opmode_pkg::B_PROMISC)
                           | (32'h1 << opmode_pkg::B_BAD_FRAMES)
                           | (32'h1 << opmode_pkg::B_RX_RUN);

    wire [31:0] mode_view = (mode_reg & mode_wmask
                             & ~(32'h1 << opmode_pkg::B_FULL_DUPLEX))
                          | ({31'h0, duplex_eff} << opmode_pkg::B_FULL_DUPLEX)
                          | ({31'h0, hash_only_reg}
                             << opmode_pkg::B_HASH_ONLY)
                          | ({31'h0, hash_perf_reg}
                             << opmode_pkg::B_HASH_PERF);
    wire [31:0] state_view = {26'h0, rx_state_reg, tx_state_reg};

    wire [31:0] rd_mux = sel_mode   ? mode_view  :
                         sel_status ? status_reg :
                         sel_state  ? state_view : 32'h0;

    // ---- transmit threshold ----
    logic [opmode_pkg::THR_W-1:0] thr_value;
    always_comb begin
        unique case ({thr_speed, thr_level})
            3'h0:    thr_value = opmode_pkg::THR_FAST_0;
            3'h1:    thr_value = opmode_pkg::THR_FAST_1;
            3'h2:    thr_value = opmode_pkg::THR_FAST_2;
            3'h3:    thr_value = opmode_pkg::THR_FAST_3;
            3'h4:    thr_value = opmode_pkg::THR_SLOW_0;
            3'h5:    thr_value = opmode_pkg::THR_SLOW_1;
            3'h6:    thr_value = opmode_pkg::THR_SLOW_2;
            default: thr_value = opmode_pkg::THR_SLOW_3;
        endcase
    end

    // ---- transmit process ----
    always_comb begin
        tx_state_next  = tx_state_reg;
        tx_unavail_set = 1'b0;
        tx_stop_set    = 1'b0;
        if (!tx_cmd) begin
            // the frame already on the wire is allowed to finish
            if (tx_state_reg != opmode_pkg::PROC_STOPPED
                && !tx_frame_busy) begin
                tx_state_next = opmode_pkg::PROC_STOPPED;
                tx_stop_set   = 1'b1;
            end
        end else begin
            unique case (tx_state_reg)
                opmode_pkg::PROC_STOPPED:
                    tx_state_next = opmode_pkg::PROC_FETCH;
                opmode_pkg::PROC_FETCH:
                    tx_state_next = opmode_pkg::PROC_WAIT_DESC;
                opmode_pkg::PROC_WAIT_DESC: begin
                    if (tx_desc_valid && tx_desc_device_owned) begin
                        tx_state_next = opmode_pkg::PROC_RUNNING;
                    end else if (tx_desc_valid) begin
                        tx_state_next  = opmode_pkg::PROC_SUSPENDED;
                        tx_unavail_set = 1'b1;
                    end
                end
                opmode_pkg::PROC_RUNNING:
                    if (tx_frame_done) begin
                        tx_state_next = opmode_pkg::PROC_FETCH;
                    end
                opmode_pkg::PROC_SUSPENDED:
                    if (tx_poll) begin
                        tx_state_next = opmode_pkg::PROC_FETCH;
                    end
                default:
                    tx_state_next = opmode_pkg::PROC_STOPPED;
            endcase
        end
    end

    // ---- receive process ----
    always_comb begin
        rx_state_next  = rx_state_reg;
        rx_unavail_set = 1'b0;
        rx_stop_set    = 1'b0;
        if (!rx_cmd) begin
            if (rx_state_reg != opmode_pkg::PROC_STOPPED
                && !rx_frame_busy) begin
                rx_state_next = opmode_pkg::PROC_STOPPED;
                rx_stop_set   = 1'b1;
            end
        end else begin
            unique case (rx_state_reg)
                opmode_pkg::PROC_STOPPED:
                    rx_state_next = opmode_pkg::PROC_FETCH;
                opmode_pkg::PROC_FETCH:
                    rx_state_next = opmode_pkg::PROC_WAIT_DESC;
                opmode_pkg::PROC_WAIT_DESC: begin
                    if (rx_desc_valid && rx_desc_device_owned) begin
                        rx_state_next = opmode_pkg::PROC_RUNNING;
                    end else if (rx_desc_valid) begin
                        rx_state_next  = opmode_pkg::PROC_SUSPENDED;
                        rx_unavail_set = 1'b1;
                    end
                end
                opmode_pkg::PROC_RUNNING:
                    if (rx_frame_done) begin
                        rx_state_next = opmode_pkg::PROC_FETCH;
                    end
                opmode_pkg::PROC_SUSPENDED:
                    if (rx_poll) begin
                        rx_state_next = opmode_pkg::PROC_FETCH;
                    end
                default:
                    rx_state_next = opmode_pkg::PROC_STOPPED;
            endcase
        end
    end

    // hardware set wins over a same-cycle software clear
    wire [31:0] status_set = ({31'h0, tx_stop_set} << opmode_pkg::B_TX_STOPPED)
                           | ({31'h0, tx_unavail_set}
                              << opmode_pkg::B_TX_UNAVAIL)
                           | ({31'h0, rx_unavail_set}
                              << opmode_pkg::B_RX_UNAVAIL)
                           | ({31'h0, rx_stop_set}
                              << opmode_pkg::B_RX_STOPPED);
    wire [31:0] status_clr = wr_status ? pwdata : 32'h0;
    wire [31:0] status_next = (status_reg & ~status_clr) | status_set;

    // ---- filter ----
    assign fif.promisc     = mode_reg[opmode_pkg::B_PROMISC];
    assign fif.all_mcast   = mode_reg[opmode_pkg::B_ALL_MCAST];
    assign fif.bad_ok      = mode_reg[opmode_pkg::B_BAD_FRAMES];
    assign fif.hash_only   = hash_only_reg;
    assign fif.hash_perf   = hash_perf_reg;
    assign fif.frame_valid = rx_frame_valid;
    assign fif.is_mcast    = rx_is_multicast;
    assign fif.is_bad      = rx_is_bad;
    assign fif.perfect_hit = rx_perfect_hit;
    assign fif.hash_hit    = rx_hash_hit;

    rx_addr_filter u_filter (
        .f (fif.filt)
    );

    // ---- registers ----
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= access & ~pready;
            pslverr <= access & ~pready & ~mapped;
            prdata  <= (access & ~pready & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg      <= opmode_pkg::MODE_RESET;
            status_reg    <= opmode_pkg::STATUS_RESET;
            hash_only_reg <= 1'b0;
            hash_perf_reg <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode_reg <= pwdata & mode_wmask;
            end
            status_reg <= status_next;
            if (setup_load) begin
                hash_only_reg <= setup_hash_only;
                hash_perf_reg <= setup_hash_perfect;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_reg <= opmode_pkg::PROC_STOPPED;
            rx_state_reg <= opmode_pkg::PROC_STOPPED;
        end else begin
            tx_state_reg <= tx_state_next;
            rx_state_reg <= rx_state_next;
        end
    end

    // ---- registered outputs ----
    wire tx_run_next = tx_state_next == opmode_pkg::PROC_RUNNING;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_desc_fetch <= 1'b0;
            rx_desc_fetch <= 1'b0;
            tx_move_data  <= 1'b0;
            tx_send_start <= 1'b0;
            rx_running    <= 1'b0;
            rx_accept     <= 1'b0;
            tx_threshold  <= opmode_pkg::THR_SLOW_0;
        end else begin
            tx_desc_fetch <= tx_state_next == opmode_pkg::PROC_FETCH;
            rx_desc_fetch <= rx_state_next == opmode_pkg::PROC_FETCH;
            tx_move_data  <= tx_run_next;
            tx_send_start <= tx_run_next && tx_fifo_level >= thr_value;
            rx_running    <= rx_state_next == opmode_pkg::PROC_RUNNING;
            rx_accept     <= fif.accept;
            tx_threshold  <= thr_value;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loopback_mode           <= opmode_pkg::LOOP_NORMAL;
            force_collision_active  <= 1'b0;
            collision_detect_enable <= 1'b1;
            full_duplex_active      <= 1'b0;
        end else begin
            loopback_mode <= loop_sel;
            force_collision_active <= mode_reg[opmode_pkg::B_FORCE_COLL]
                && loop_sel == opmode_pkg::LOOP_INTERNAL;
            collision_detect_enable <=
                loop_sel != opmode_pkg::LOOP_EXTERNAL;
            full_duplex_active <= duplex_eff;
        end
    end
endmodule : mac_operation_mode_control

/* File: verif/mac_opmode_sva.sv */
// assertions on the operation mode control top module ports
`timescale 1ns/1ps
module mac_opmode_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        tx_desc_fetch,
    input wire logic        rx_desc_fetch,
    input wire logic        tx_move_data,
    input wire logic        tx_send_start,
    input wire logic [10:0] tx_fifo_level,
    input wire logic [10:0] tx_threshold,
    input wire logic [1:0]  loopback_mode,
    input wire logic        force_collision_active,
    input wire logic        collision_detect_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence acc_wait;
        psel && penable && !pready;
    endsequence
    sequence fetch_pulse(s);
        s ##1 !s;
    endsequence
    chk_apb_wait: assert property (acc_wait |=> pready)
        else $error("access not answered after one wait state");
    chk_ready_once: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready outside an access or held too long");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_tx_fetch: assert property (tx_desc_fetch |-> fetch_pulse(tx_desc_fetch))
        else $error("tx fetch request longer than one cycle");
    chk_rx_fetch: assert property (rx_desc_fetch |-> fetch_pulse(rx_desc_fetch))
        else $error("rx fetch request longer than one cycle");
    chk_send_level: assert property (tx_send_start |-> tx_move_data &&
        $past(tx_fifo_level) >= $past(tx_threshold))
        else $error("send started below threshold");
    chk_force_loop: assert property (force_collision_active |->
        loopback_mode == opmode_pkg::LOOP_INTERNAL)
        else $error("forced collision outside internal loopback");
    chk_ext_nocoll: assert property (loopback_mode ==
        opmode_pkg::LOOP_EXTERNAL |-> !collision_detect_enable)
        else $error("collision detect on in external loopback");
    chk_thr_legal: assert property (tx_threshold inside {11'h040, 11'h080,
        11'h0C0, 11'h100, 11'h200, 11'h400})
        else $error("threshold not a legal value");
endmodule : mac_opmode_sva
bind mac_operation_mode_control mac_opmode_sva u_sva (.pclk, .presetn,
    .psel, .penable, .pready, .pslverr, .tx_desc_fetch, .rx_desc_fetch,
    .tx_move_data, .tx_send_start, .tx_fifo_level, .tx_threshold,
    .loopback_mode, .force_collision_active, .collision_detect_enable);

/* File: verif/desc_host_model.sv */
// host descriptor memory: answers fetches after a latency
`timescale 1ns/1ps
module desc_host_model #(parameter int LAT = 3) (
    input wire logic pclk, presetn, tx_desc_fetch, rx_desc_fetch,
    input wire logic tx_own, rx_own,
    output logic     tx_desc_valid, tx_desc_device_owned,
    output logic     rx_desc_valid, rx_desc_device_owned
);
    logic [3:0] tc, rc;
    // ownership line toggles when not qualified, so stale values never pass
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {tc, rc} <= 8'h00;
            {tx_desc_valid, tx_desc_device_owned} <= 2'h0;
            {rx_desc_valid, rx_desc_device_owned} <= 2'h0;
        end else begin
            tx_desc_valid <= (tc == 4'h1);
            rx_desc_valid <= (rc == 4'h1);
            tx_desc_device_owned <= (tc == 4'h1) ? tx_own : ~tx_desc_device_owned;
            rx_desc_device_owned <= (rc == 4'h1) ? rx_own : ~rx_desc_device_owned;
            tc <= tx_desc_fetch ? 4'(LAT) : (tc != 4'h0 ? tc - 4'h1 : 4'h0);
            rc <= rx_desc_fetch ? 4'(LAT) : (rc != 4'h0 ? rc - 4'h1 : 4'h0);
        end
    end
endmodule : desc_host_model

/* File: verif/mac_operation_mode_control_tb.sv */
// self-checking bench for the operation mode control block
`timescale 1ns/1ps
module mac_operation_mode_control_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic setup_load = 0, setup_hash_only = 0, setup_hash_perfect = 0;
    logic ext_phy_select = 0, phy_full_duplex = 0, tx_own = 0, rx_own = 0;
    logic tx_frame_busy = 0, tx_frame_done = 0, rx_frame_busy = 0;
    logic rx_frame_done = 0, rx_frame_valid = 0, rx_is_multicast = 0;
    logic rx_is_bad = 0, rx_perfect_hit = 0, rx_hash_hit = 0, slv;
    logic [31:0] paddr = 0, pwdata = 0, prdata, r;
    logic [10:0] tx_fifo_level = 0, tx_threshold;
    logic [1:0] loopback_mode;
    logic pready, pslverr, tx_desc_fetch, tx_desc_valid, tx_move_data;
    logic tx_desc_device_owned, tx_send_start, rx_desc_fetch, rx_running;
    logic rx_desc_valid, rx_desc_device_owned, rx_accept, full_duplex_active;
    logic force_collision_active, collision_detect_enable;
    int err_total = 0, samples_checked = 0, cyc = 0;
    mac_operation_mode_control uut (.*);
    desc_host_model host (.*);
    initial forever #4 pclk = ~pclk;
    always @(posedge pclk) if (++cyc == 20000) begin
        err_total++;
        report_and_stop();
    end
    task report_and_stop();
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [31:0] a, d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        r = prdata;
        slv = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : wt
    task poll_state(input logic [31:0] m, e);
        int n;
        n = 0;
        do apb(0, 32'h8, 0); while ((r & m) !== e && ++n < 20);
        chk(r & m, e);
    endtask : poll_state
    task setup(input logic ho, hp);
        @(posedge pclk);
        {setup_hash_only, setup_hash_perfect, setup_load} <= {ho, hp, 1'b1};
        @(posedge pclk);
        setup_load <= 0;
    endtask : setup
    task filt(input logic [31:0] m, input logic [4:0] v, input logic e);
        apb(1, 32'h0, m);
        @(posedge pclk);
        {rx_frame_valid, rx_is_multicast, rx_is_bad, rx_perfect_hit,
            rx_hash_hit} <= v;
        wt(3);
        chk(rx_accept, e);
    endtask : filt
    task t_regs();
        apb(0, 32'h0, 0);
        chk(r, 32'h0040_0040);
        chk(tx_threshold, 11'h040);
        apb(1, 32'h0, 32'hFFBF_0135);
        apb(0, 32'h0, 0);
        chk(r, 32'h0);
        apb(0, 32'h10, 0);
        chk({r, slv}, {32'h0, 1'b1});
        for (int i = 0; i < 8; i++) begin
            apb(1, 32'h0, (i / 4) << 22 | (i % 4) << 14);
            wt(3);
            chk(tx_threshold, i > 3 ? 64 * (i % 4 + 1) : 128 << i % 4);
        end
        for (int i = 0; i < 4; i++) begin
            apb(1, 32'h0, 32'h1000 | i << 10);
            wt(3);
            chk(loopback_mode, i);
            chk(force_collision_active, i == 1);
            chk(collision_detect_enable, i != 2);
        end
        ext_phy_select <= 1;
        apb(1, 32'h0, 32'h200);
        wt(3);
        chk(full_duplex_active, 1);
        ext_phy_select <= 0;
        phy_full_duplex <= 1;
        apb(1, 32'h0, 0);
        wt(3);
        chk(full_duplex_active, 1);
        apb(0, 32'h0, 0);
        chk(r & 32'h200, 32'h200);
    endtask : t_regs
    task t_filter();
        setup(0, 0);
        filt(32'h40, 5'b10100, 0);
        filt(32'h48, 5'b10100, 1);
        filt(32'h40, 5'b10000, 1);
        filt(32'h80, 5'b11000, 1);
        filt(32'h80, 5'b10000, 0);
        filt(32'h08, 5'b10110, 1);
        filt(32'h00, 5'b10001, 0);
        filt(32'h00, 5'b10010, 1);
        setup(0, 1);
        filt(32'h00, 5'b11001, 1);
        filt(32'h00, 5'b10001, 0);
        chk(r, 32'h0);
        apb(0, 32'h0, 0);
        chk(r & 5, 1);
        setup(1, 1);
        filt(32'h00, 5'b10001, 1);
        apb(0, 32'h0, 0);
        chk(r & 5, 5);
    endtask : t_filter
    task t_tx();
        apb(1, 32'h0, 32'h2000);
        poll_state(7, 4);
        apb(0, 32'h4, 0);
        chk(r & 4, 4);
        tx_own <= 1;
        apb(1, 32'hC, 1);
        poll_state(7, 3);
        tx_fifo_level <= 11'h07F;
        wt(3);
        chk({tx_move_data, tx_send_start}, 2'b10);
        tx_fifo_level <= 11'h080;
        wt(3);
        chk(tx_send_start, 1);
        tx_frame_busy <= 1;
        apb(1, 32'h0, 0);
        wt(4);
        poll_state(7, 3);
        tx_frame_busy <= 0;
        poll_state(7, 0);
        apb(0, 32'h4, 0);
        chk(r & 2, 2);
    endtask : t_tx
    task t_rx();
        apb(1, 32'h0, 32'h2);
        poll_state(32'h38, 32'h20);
        apb(0, 32'h4, 0);
        chk(r & 32'h80, 32'h80);
        rx_own <= 1;
        apb(1, 32'hC, 2);
        poll_state(32'h38, 32'h18);
        chk(rx_running, 1);
        rx_frame_busy <= 1;
        apb(1, 32'h0, 0);
        wt(4);
        chk(rx_running, 1);
        rx_frame_busy <= 0;
        poll_state(32'h38, 0);
        apb(0, 32'h4, 0);
        chk(r & 32'h100, 32'h100);
    endtask : t_rx
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1;
        t_regs();
        t_filter();
        t_tx();
        t_rx();
        report_and_stop();
    end
endmodule : mac_operation_mode_control_tb
